//--- shared/led_regs_pkg.sv
// Behaviour
// - fader code 1-3 faders, 5 PWM input
// - ratiometric bit keeps RGB colour constant
// - curve bit 0 linear, 1 exponential
// - curve applies to engine and direct drive
// - supply bit 0 charge pump, 1 external
// - config registers reset to all zero
// - duty 00h 0%, 80h 50%, FFh 100%
// - one duty register per output, reset zero
package led_regs_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CH7_CONFIG_ADDR = 8'h0E;
  localparam logic [7:0] CH8_CONFIG_ADDR = 8'h0F;
  localparam logic [7:0] CH0_DUTY_ADDR = 8'h16;
  localparam logic [7:0] CH1_DUTY_ADDR = 8'h17;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ----------------------------------------------------------------
  // config field positions
  // ----------------------------------------------------------------
  localparam int FADER_MSB = 7;
  localparam int FADER_LSB = 5;
  localparam int RATIO_BIT = 4;
  localparam int CURVE_BIT = 3;
  localparam int SUPPLY_BIT = 2;
  localparam logic [2:0] FADER_CODE_F1 = 3'h1;
  localparam logic [2:0] FADER_CODE_F2 = 3'h2;
  localparam logic [2:0] FADER_CODE_F3 = 3'h3;
  localparam logic [2:0] FADER_CODE_PWMIN = 3'h5;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 25_000_000;
  localparam int PWM_FREQ_HZ = 20_000;
  localparam int PWM_STEPS = 255;
  // longest tick period rounds down, never below one cycle
  localparam int PWM_TICK_RAW = CLOCK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam int PWM_TICK_CYCLES = (PWM_TICK_RAW < 1) ? 1 : PWM_TICK_RAW;

  typedef enum logic [4:0] {
    FM_NONE = 5'b00001,
    FM_FADER1 = 5'b00010,
    FM_FADER2 = 5'b00100,
    FM_FADER3 = 5'b01000,
    FM_PWM_IN = 5'b10000
  } fader_mode_t;
endpackage : led_regs_pkg

//--- hdl/duty_pwm_gen.sv
`timescale 1ns/1ps
module duty_pwm_gen #(
  parameter int WIDTH = 8
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic TICK,
  input wire logic [WIDTH-1:0] DUTY,
  output logic OUT
);
  import led_regs_pkg::*;

  localparam logic [WIDTH-1:0] LAST_STEP = {{(WIDTH-1){1'b1}}, 1'b0};

  initial begin
    if (WIDTH < 2) begin
      $error("duty_pwm_gen needs WIDTH of at least 2");
    end
  end

  logic [WIDTH-1:0] step;

  // ----------------------------------------------------------------
  // period counter, 0 .. 2^WIDTH-2
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      step <= '0;
    end else if (TICK) begin
      step <= (step == LAST_STEP) ? '0 : step + 1'b1;
    end
  end

  // proportional on-time
  // full code exceeds every step, so it stays on
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      OUT <= 1'b0;
    end else begin
      OUT <= (step < DUTY);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] on_count;
  logic duty_steady;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      on_count <= '0;
      duty_steady <= 1'b0;
    end else if (TICK && step == LAST_STEP) begin
      on_count <= '0;
      duty_steady <= 1'b1;
    end else begin
      if (TICK && step < DUTY) begin
        on_count <= on_count + 1'b1;
      end
      if ($changed(DUTY)) begin
        duty_steady <= 1'b0;
      end
    end
  end

  property p_duty_ends;
    @(posedge CLOCK) disable iff (!RST_N)
      (DUTY == '0) ##1 (DUTY == '0) |-> !OUT;
  endproperty
  a_duty_ends: assert property (p_duty_ends) else $error("duty zero yet output high");

  property p_duty_full;
    @(posedge CLOCK) disable iff (!RST_N)
      (DUTY == '1) ##1 (DUTY == '1) |-> OUT;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("duty full yet output low");

  property p_on_ratio;
    @(posedge CLOCK) disable iff (!RST_N)
      (TICK && step == LAST_STEP && duty_steady && !$changed(DUTY))
        |-> (on_count + ((LAST_STEP < DUTY) ? 1'b1 : 1'b0)) == DUTY;
  endproperty
  a_on_ratio: assert property (p_on_ratio) else $error("on time not equal to duty");
endmodule : duty_pwm_gen

//--- hdl/led_channel_control_regs.sv
`timescale 1ns/1ps
module led_channel_control_regs #(
  parameter int TICK_CYCLES = led_regs_pkg::PWM_TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [7:0] REG_RDATA,
  output led_regs_pkg::fader_mode_t FADER_MODE_CH7,
  output led_regs_pkg::fader_mode_t FADER_MODE_CH8,
  output logic RATIO_EN_CH7,
  output logic RATIO_EN_CH8,
  output logic EXT_SUPPLY_CH7,
  output logic EXT_SUPPLY_CH8,
  input wire logic ENGINE_DRIVE_CH7,
  input wire logic ENGINE_DRIVE_CH8,
  input wire logic [7:0] ENGINE_LEVEL_CH7,
  input wire logic [7:0] ENGINE_LEVEL_CH8,
  input wire logic [7:0] DIRECT_LEVEL_CH7,
  input wire logic [7:0] DIRECT_LEVEL_CH8,
  output logic [7:0] ADJ_LEVEL_CH7,
  output logic [7:0] ADJ_LEVEL_CH8,
  output logic [1:0] PWM_OUT
);
  import led_regs_pkg::*;

  initial begin
    // the step divider is 16 bits wide, so longer ticks cannot be counted
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin
      $error("TICK_CYCLES must be 1 to 65536");
    end
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // fader decode
  function automatic fader_mode_t decode_fader(input logic [2:0] code);
    case (code)
      FADER_CODE_F1: decode_fader = FM_FADER1;
      FADER_CODE_F2: decode_fader = FM_FADER2;
      FADER_CODE_F3: decode_fader = FM_FADER3;
      FADER_CODE_PWMIN: decode_fader = FM_PWM_IN;
      default: decode_fader = FM_NONE;
    endcase
  endfunction : decode_fader

  // curve shaping
  // square law stands in for the exponential curve; endpoints are exact
  function automatic logic [7:0] shape(input logic [7:0] lvl, input logic expo);
    logic [15:0] sq;
    sq = 16'(lvl) * 16'(lvl);
    if (!expo || lvl == DUTY_FULL) begin
      shape = lvl;
    end else begin
      shape = sq[15:8];
    end
  endfunction : shape

  logic [7:0] channel7_config;
  logic [7:0] channel8_config;
  logic [7:0] duty [2];
  logic [7:0] src7;
  logic [7:0] src8;
  logic curve_select_ch7;
  logic curve_select_ch8;

  // ----------------------------------------------------------------
  // config registers
  // ----------------------------------------------------------------
  // zero reset
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      channel7_config <= CONFIG_RESET;
      channel8_config <= CONFIG_RESET;
    end else if (REG_WE) begin
      if (REG_ADDR == CH7_CONFIG_ADDR) begin
        channel7_config <= REG_WDATA;
      end
      if (REG_ADDR == CH8_CONFIG_ADDR) begin
        channel8_config <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      duty[0] <= DUTY_RESET;
      duty[1] <= DUTY_RESET;
    end else if (REG_WE) begin
      if (REG_ADDR == CH0_DUTY_ADDR) begin
        duty[0] <= REG_WDATA;
      end
      if (REG_ADDR == CH1_DUTY_ADDR) begin
        duty[1] <= REG_WDATA;
      end
    end
  end

  // reserved bits keep what was written
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      REG_RDATA <= UNMAPPED_READ;
    end else if (REG_RE) begin
      case (REG_ADDR)
        CH7_CONFIG_ADDR: REG_RDATA <= channel7_config;
        CH8_CONFIG_ADDR: REG_RDATA <= channel8_config;
        CH0_DUTY_ADDR: REG_RDATA <= duty[0];
        CH1_DUTY_ADDR: REG_RDATA <= duty[1];
        default: REG_RDATA <= UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  // fader routing
  assign FADER_MODE_CH7 = decode_fader(channel7_config[FADER_MSB:FADER_LSB]);
  assign FADER_MODE_CH8 = decode_fader(channel8_config[FADER_MSB:FADER_LSB]);
  assign RATIO_EN_CH7 = channel7_config[RATIO_BIT];
  assign RATIO_EN_CH8 = channel8_config[RATIO_BIT];
  assign EXT_SUPPLY_CH7 = channel7_config[SUPPLY_BIT];
  assign EXT_SUPPLY_CH8 = channel8_config[SUPPLY_BIT];
  assign curve_select_ch7 = channel7_config[CURVE_BIT];
  assign curve_select_ch8 = channel8_config[CURVE_BIT];

  // curve on both sources
  // the source only picks the level; the curve follows either way
  assign src7 = ENGINE_DRIVE_CH7 ? ENGINE_LEVEL_CH7 : DIRECT_LEVEL_CH7;
  assign src8 = ENGINE_DRIVE_CH8 ? ENGINE_LEVEL_CH8 : DIRECT_LEVEL_CH8;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ADJ_LEVEL_CH7 <= '0;
      ADJ_LEVEL_CH8 <= '0;
    end else begin
      ADJ_LEVEL_CH7 <= shape(src7, curve_select_ch7);
      ADJ_LEVEL_CH8 <= shape(src8, curve_select_ch8);
    end
  end

  // ----------------------------------------------------------------
  // pwm step enable and generators
  // ----------------------------------------------------------------
  logic [15:0] tick_div;
  logic tick;
  assign tick = (tick_div == 16'(TICK_CYCLES - 1));
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      tick_div <= '0;
    end else begin
      tick_div <= tick ? '0 : tick_div + 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pwm
      duty_pwm_gen #(.WIDTH(8)) u_pwm (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .TICK(tick),
        .DUTY(duty[g]),
        .OUT(PWM_OUT[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_write(logic [7:0] a);
    REG_WE && REG_ADDR == a;
  endsequence

  property p_fader_pwmin;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(CH7_CONFIG_ADDR) ##0 (REG_WDATA[7:5] == 3'h5) |=> FADER_MODE_CH7 == FM_PWM_IN;
  endproperty
  a_fader_pwmin: assert property (p_fader_pwmin) else $error("code 5 not pwm fading");

  property p_fader_none;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(CH8_CONFIG_ADDR) ##0 (REG_WDATA[7:5] inside {3'h0, 3'h4, 3'h6, 3'h7})
        |=> FADER_MODE_CH8 == FM_NONE;
  endproperty
  a_fader_none: assert property (p_fader_none) else $error("unused code not none");

  property p_ratio;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(CH7_CONFIG_ADDR) |=> RATIO_EN_CH7 == $past(REG_WDATA[4]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratiometric bit lost");

  property p_linear;
    @(posedge CLOCK) disable iff (!RST_N)
      !curve_select_ch8 |=> ADJ_LEVEL_CH8 == $past(src8);
  endproperty
  a_linear: assert property (p_linear) else $error("linear level altered");

  property p_source_free;
    @(posedge CLOCK) disable iff (!RST_N)
      curve_select_ch7 && ENGINE_DRIVE_CH7 && ENGINE_LEVEL_CH7 == 8'h80
        |=> ADJ_LEVEL_CH7 == 8'h40;
  endproperty
  a_source_free: assert property (p_source_free) else $error("engine level not curved");

  property p_supply;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(CH8_CONFIG_ADDR) |=> EXT_SUPPLY_CH8 == $past(REG_WDATA[2]);
  endproperty
  a_supply: assert property (p_supply) else $error("supply bit lost");

  property p_reset_zero;
    @(posedge CLOCK) !RST_N |=> channel7_config == 8'h00 && channel8_config == 8'h00
      && FADER_MODE_CH7 == FM_NONE && !EXT_SUPPLY_CH8;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not cleared");

  property p_duty_own;
    @(posedge CLOCK) disable iff (!RST_N)
      s_write(CH0_DUTY_ADDR) |=> duty[0] == $past(REG_WDATA) && $stable(duty[1]);
  endproperty
  a_duty_own: assert property (p_duty_own) else $error("duty write crossed channels");
endmodule : led_channel_control_regs

//--- verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic CLOCK,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WE,
  output logic REG_RE,
  input wire logic [7:0] REG_RDATA
);
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WE = 1'b0;
    REG_RE = 1'b0;
  end
  // ----------------------------------------------------------------
  // register port cycles
  // ----------------------------------------------------------------
  // idle bus never keeps the last value, so a stale sample cannot pass
  task automatic idle();
    REG_ADDR = ~REG_ADDR;
    REG_WDATA = ~REG_WDATA;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WE = 1'b1;
    @(posedge CLOCK);
    #1;
    REG_WE = 1'b0;
    idle();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    #1;
    REG_ADDR = a;
    REG_RE = 1'b1;
    @(posedge CLOCK);
    #1;
    REG_RE = 1'b0;
    d = REG_RDATA;
    idle();
  endtask : rd
endmodule : host_model

//--- verif/test_led_channel_control_regs.sv
`timescale 1ns/1ps
module test_led_channel_control_regs;
  import led_regs_pkg::*;
  logic clock, rst_n, we, re;
  logic [7:0] addr, wdata, rdata, got, lvl7, lvl8;
  logic [7:0] eng7, eng8, dir7, dir8;
  logic drv7, drv8;
  logic [1:0] pwm;
  fader_mode_t mode7, mode8;
  logic ratio7, ratio8, ext7, ext8;
  int err_count, checks_done, cycles, on0, on1;
  logic [7:0] vals [4] = '{8'h00, 8'h80, 8'hFF, 8'h37};
  logic [7:0] regs [4] = '{CH7_CONFIG_ADDR, CH8_CONFIG_ADDR, CH0_DUTY_ADDR, CH1_DUTY_ADDR};

  host_model host (.CLOCK(clock), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
    .REG_RE(re), .REG_RDATA(rdata));
  led_channel_control_regs #(.TICK_CYCLES(1)) dut (.CLOCK(clock), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
    .FADER_MODE_CH7(mode7), .FADER_MODE_CH8(mode8), .RATIO_EN_CH7(ratio7),
    .RATIO_EN_CH8(ratio8), .EXT_SUPPLY_CH7(ext7), .EXT_SUPPLY_CH8(ext8),
    .ENGINE_DRIVE_CH7(drv7), .ENGINE_DRIVE_CH8(drv8), .ENGINE_LEVEL_CH7(eng7),
    .ENGINE_LEVEL_CH8(eng8), .DIRECT_LEVEL_CH7(dir7), .DIRECT_LEVEL_CH8(dir8),
    .ADJ_LEVEL_CH7(lvl7), .ADJ_LEVEL_CH8(lvl8), .PWM_OUT(pwm));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  function automatic fader_mode_t fmode(input logic [2:0] c);
    case (c)
      3'h1: return FM_FADER1;
      3'h2: return FM_FADER2;
      3'h3: return FM_FADER3;
      3'h5: return FM_PWM_IN;
      default: return FM_NONE;
    endcase
  endfunction : fmode
  // square law with exact full scale, as agreed for the exponential curve
  function automatic logic [7:0] curve(input logic [7:0] x, input logic e);
    if (!e || x == 8'hFF) return x;
    return 8'((16'(x) * 16'(x)) >> 8);
  endfunction : curve
  task automatic count_on();
    on0 = 0;
    on1 = 0;
    repeat (4) @(posedge clock);
    repeat (255) begin
      @(posedge clock);
      #1;
      on0 += int'(pwm[0] === 1'b1);
      on1 += int'(pwm[1] === 1'b1);
    end
  endtask : count_on
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_n, drv7, drv8, eng7, eng8, dir7, dir8} = '0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    foreach (vals[i]) begin
      host.rd(regs[i], got);
      chk(got, 8'h00);
    end
    chk({3'h0, mode7}, {3'h0, FM_NONE});
    chk({4'h0, ratio7, ext8, pwm}, 8'h00);
    // every fader code on both channels
    for (int c = 0; c < 8; c++) begin
      host.wr(CH7_CONFIG_ADDR, {3'(c), 5'h14});
      host.wr(CH8_CONFIG_ADDR, {3'(7 - c), c[0], 1'b0, c[1], 2'h3});
      chk({3'h0, mode7}, {3'h0, fmode(3'(c))});
      chk({3'h0, mode8}, {3'h0, fmode(3'(7 - c))});
      chk({4'h0, ratio7, ext7, ratio8, ext8}, {6'h03, c[0], c[1]});
    end
    // reserved bits stored, unmapped place ignored
    host.wr(8'h10, 8'h5A);
    host.rd(8'h10, got);
    chk(got, UNMAPPED_READ);
    host.rd(CH8_CONFIG_ADDR, got);
    chk(got, 8'h17);
    // curve on engine and direct paths, each channel both ways
    for (int d = 0; d < 2; d++) begin
      host.wr(CH7_CONFIG_ADDR, d[0] ? 8'h08 : 8'h00);
      host.wr(CH8_CONFIG_ADDR, d[0] ? 8'h00 : 8'h08);
      foreach (vals[i]) begin
        @(posedge clock);
        #1;
        {drv7, drv8} = {2{d[0]}};
        {eng7, eng8} = {2{vals[i]}};
        {dir7, dir8} = {2{~vals[i]}};
        repeat (2) @(posedge clock);
        #1;
        chk(lvl7, curve(d[0] ? vals[i] : ~vals[i], d[0]));
        chk(lvl8, curve(d[0] ? vals[i] : ~vals[i], !d[0]));
      end
    end
    // duty endpoints and midpoints, both outputs at once with values in reverse order
    foreach (vals[i]) begin
      host.wr(CH0_DUTY_ADDR, vals[i]);
      host.wr(CH1_DUTY_ADDR, vals[3 - i]);
      host.rd(CH0_DUTY_ADDR, got);
      chk(got, vals[i]);
      count_on();
      chk(8'(on0), vals[i]);
      chk(8'(on1), vals[3 - i]);
    end
    conclude();
  end
endmodule : test_led_channel_control_regs
